// [verilog/ghem_top.sv]
// Game history, audit tallies and fault supervision with AXI4-Lite registers
// What this block does
// - Flashing and non-flashing exit tallies per target
// - Tally gate faults and sensor blocked faults
// - Audits freeze at games ceiling until cleared
// - Keep points and tickets of five games
// - History lost at power; empty slot blank
// - Enter history from audits or sixth press
// - Service steps title then wraps entries
// - Each game shows points then tickets
// - Test press in history returns attract
// - Fault shows number and requests voice
// - Ticket fault: no notch for 3 s
// - Coin fault: switch closed over 5 s
// - Memory fault shown in all modes but attract
// - Gate fault after game; Test closes gate
// - Sensor fault: beam blocked over 3 s
// - Sensor fault clears itself when unblocked
// - Test press rechecks; fault stays if present
// - Owed tickets paid after ticket fault clears
`default_nettype none
module ghem_top #(
	parameter int NUM_COIN    = 2,
	parameter int NOTCH_LIMIT = ghem_pkg::NOTCH_TIMEOUT_CYC,
	parameter int COIN_LIMIT  = ghem_pkg::COIN_STUCK_CYC,
	parameter int BEAM_LIMIT  = ghem_pkg::BEAM_BLOCK_CYC
) (
	// Clock and reset
	input  wire logic                              CLK,
	input  wire logic                              RESETN,
	// AXI4-Lite slave
	input  wire logic [7:0]                        S_AXI_AWADDR,
	input  wire logic                              S_AXI_AWVALID,
	output logic                                   S_AXI_AWREADY,
	input  wire logic [31:0]                       S_AXI_WDATA,
	input  wire logic [3:0]                        S_AXI_WSTRB,
	input  wire logic                              S_AXI_WVALID,
	output logic                                   S_AXI_WREADY,
	output logic [1:0]                             S_AXI_BRESP,
	output logic                                   S_AXI_BVALID,
	input  wire logic                              S_AXI_BREADY,
	input  wire logic [7:0]                        S_AXI_ARADDR,
	input  wire logic                              S_AXI_ARVALID,
	output logic                                   S_AXI_ARREADY,
	output logic [31:0]                            S_AXI_RDATA,
	output logic [1:0]                             S_AXI_RRESP,
	output logic                                   S_AXI_RVALID,
	input  wire logic                              S_AXI_RREADY,
	// Interrupt
	output logic                                   IRQ,
	// Buttons and sensor pins
	input  wire logic                              TEST_BTN,
	input  wire logic                              SERVICE_BTN,
	input  wire logic [NUM_COIN-1:0]               COIN_SW,
	input  wire logic                              NOTCH,
	input  wire logic                              GATE_CLOSED,
	input  wire logic [ghem_pkg::NUM_TARGETS-1:0]  TARGET_BEAM,
	// Game logic on the same clock
	input  wire logic                              GAME_END,
	input  wire logic [ghem_pkg::VAL_W-1:0]        GAME_POINTS,
	input  wire logic [ghem_pkg::VAL_W-1:0]        GAME_TICKETS,
	input  wire logic [ghem_pkg::NUM_TARGETS-1:0]  TARGET_FLASH,
	input  wire logic                              SETTINGS_MEM_ERR,
	// Outputs to machine
	output ghem_pkg::ghem_disp_type                DISPLAY,
	output logic                                   VOICE_REQ,
	output logic                                   DISPENSE,
	output logic                                   GATE_CLOSE_CMD,
	output logic                                   PLAY_HALT
);
	import ghem_pkg::*;

	localparam int SW = NUM_COIN + 7;
	localparam logic [TMR_W-1:0] NOTCH_LIM = TMR_W'(NOTCH_LIMIT);
	localparam logic [TMR_W-1:0] COIN_LIM  = TMR_W'(COIN_LIMIT);
	localparam logic [TMR_W-1:0] BEAM_LIM  = TMR_W'(BEAM_LIMIT);

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pin synchronisers
	logic          rst_meta_ff;
	logic          rst_n;
	logic [SW-1:0] pin_meta_ff;
	logic [SW-1:0] pin_ff;
	logic [SW-1:0] pin_prev_ff;
	logic [SW-1:0] pin_rise;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= '0;
			pin_ff      <= '0;
			pin_prev_ff <= '0;
		end else begin
			pin_meta_ff <= {TARGET_BEAM, GATE_CLOSED, NOTCH, COIN_SW, SERVICE_BTN, TEST_BTN};
			pin_ff      <= pin_meta_ff;
			pin_prev_ff <= pin_ff;
		end
	end

	assign pin_rise = pin_ff & ~pin_prev_ff;

	logic                   test_rise;
	logic                   svc_rise;
	logic                   coin_any;
	logic                   notch_rise;
	logic                   gate_closed;
	logic [NUM_TARGETS-1:0] beam;
	logic [NUM_TARGETS-1:0] beam_rise;

	assign test_rise   = pin_rise[0];
	assign svc_rise    = pin_rise[1];
	assign coin_any    = |pin_ff[NUM_COIN+1:2];
	assign notch_rise  = pin_rise[NUM_COIN+2];
	assign gate_closed = pin_ff[NUM_COIN+3];
	assign beam        = pin_ff[NUM_COIN+6:NUM_COIN+4];
	assign beam_rise   = pin_rise[NUM_COIN+6:NUM_COIN+4];

	////////////////////////////////////////////////////////////////////////////
	// Operator mode
	ghem_mode_type mode_ff;
	logic [2:0]    press_cnt_ff;
	logic [3:0]    step_ff;
	logic [4:0]    faults_ff;
	logic [4:0]    vis_faults;
	logic          err_shown;
	logic          nav_press;

	// Memory fault stays hidden outside the test screens
	assign vis_faults = faults_ff & ~((mode_ff == MODE_ATTRACT) ? 5'h04 : 5'h00);
	assign err_shown  = |vis_faults;
	// A Test press is taken by the fault recheck first
	assign nav_press  = test_rise & ~err_shown;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff      <= MODE_ATTRACT;
			press_cnt_ff <= '0;
			step_ff      <= '0;
		end else begin
			case (mode_ff)
				MODE_ATTRACT: begin
					if (nav_press) begin
						mode_ff      <= MODE_TEST;
						press_cnt_ff <= 3'h1;
					end
				end
				MODE_TEST: begin
					if (nav_press) begin
						press_cnt_ff <= press_cnt_ff + 3'h1;
						if (press_cnt_ff + 3'h1 == AUDIT_ENTRY_PRESSES) begin
							mode_ff <= MODE_AUDIT;
						end
					end
				end
				MODE_AUDIT: begin
					if (nav_press) begin
						mode_ff <= MODE_HISTORY;
						step_ff <= '0;
					end
				end
				MODE_HISTORY: begin
					if (nav_press) begin
						mode_ff      <= MODE_ATTRACT;
						press_cnt_ff <= '0;
					end else if (svc_rise) begin
						step_ff <= (step_ff == HIST_LAST_STEP) ? 4'h1 : step_ff + 4'h1;
					end
				end
				default: begin
					mode_ff <= MODE_ATTRACT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Game history, volatile by design
	ghem_hist_type           hist_ff [NUM_HIST];
	logic [NUM_HIST-1:0]     hist_valid_ff;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_HIST; i++) begin
				hist_ff[i] <= '0;
			end
			hist_valid_ff <= '0;
		end else if (GAME_END) begin
			for (int i = NUM_HIST - 1; i > 0; i--) begin
				hist_ff[i] <= hist_ff[i-1];
			end
			hist_ff[0]    <= '{points: GAME_POINTS, tickets: GAME_TICKETS};
			hist_valid_ff <= {hist_valid_ff[NUM_HIST-2:0], 1'b1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Supervision timers
	logic [TMR_W-1:0] notch_tmr_ff;
	logic [TMR_W-1:0] coin_tmr_ff;
	logic [TMR_W-1:0] beam_tmr_ff [NUM_TARGETS];
	logic [NUM_TARGETS-1:0] beam_stuck;
	logic [OWED_W-1:0] owed_ff;
	logic              dispensing;

	assign dispensing = (owed_ff != '0) & ~faults_ff[FLT_TICKET];

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			notch_tmr_ff <= '0;
		end else if (!dispensing || notch_rise) begin
			notch_tmr_ff <= '0;
		end else if (notch_tmr_ff != NOTCH_LIM) begin
			notch_tmr_ff <= notch_tmr_ff + 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			coin_tmr_ff <= '0;
		end else if (!coin_any) begin
			coin_tmr_ff <= '0;
		end else if (coin_tmr_ff != COIN_LIM) begin
			coin_tmr_ff <= coin_tmr_ff + 1'b1;
		end
	end

	for (genvar t = 0; t < NUM_TARGETS; t++) begin : g_beam
		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				beam_tmr_ff[t] <= '0;
			end else if (!beam[t]) begin
				beam_tmr_ff[t] <= '0;
			end else if (beam_tmr_ff[t] != BEAM_LIM) begin
				beam_tmr_ff[t] <= beam_tmr_ff[t] + 1'b1;
			end
		end
		assign beam_stuck[t] = (beam_tmr_ff[t] == BEAM_LIM);
	end

	// Owed tickets survive a ticket fault
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			owed_ff <= '0;
		end else begin
			owed_ff <= owed_ff + (GAME_END ? OWED_W'(GAME_TICKETS) : '0)
				- OWED_W'(notch_rise && owed_ff != '0);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Faults
	logic [4:0] fault_set;
	logic [4:0] fault_clr;
	logic [4:0] nxt_faults;
	logic [4:0] fault_new;

	always_comb begin
		fault_set             = '0;
		fault_set[FLT_TICKET] = (notch_tmr_ff == NOTCH_LIM) & dispensing;
		fault_set[FLT_COIN]   = (coin_tmr_ff == COIN_LIM);
		fault_set[FLT_MEM]    = SETTINGS_MEM_ERR;
		fault_set[FLT_GATE]   = GAME_END & ~gate_closed;
		// Level causes set again at once, so a recheck cannot hide them
		fault_clr             = (test_rise && err_shown) ? 5'h0F : 5'h00;
		nxt_faults            = (faults_ff & ~fault_clr) | fault_set;
		nxt_faults[FLT_SENSOR] = |beam_stuck;
	end

	assign fault_new = nxt_faults & ~faults_ff;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			faults_ff      <= '0;
			VOICE_REQ      <= 1'b0;
			GATE_CLOSE_CMD <= 1'b0;
			PLAY_HALT      <= 1'b0;
			DISPENSE       <= 1'b0;
		end else begin
			faults_ff      <= nxt_faults;
			VOICE_REQ      <= |fault_new;
			GATE_CLOSE_CMD <= fault_clr[FLT_GATE] & faults_ff[FLT_GATE];
			PLAY_HALT      <= err_shown;
			DISPENSE       <= dispensing;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Display
	ghem_disp_type nxt_disp;
	logic [3:0]    slot_idx;

	always_comb begin
		nxt_disp = '{kind: DISP_IDLE, slot: 3'h0, value: '0};
		slot_idx = (step_ff - 4'h1) >> 1;
		if (err_shown) begin
			nxt_disp.kind = DISP_ERROR;
			for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
				if (vis_faults[i]) begin
					nxt_disp.slot = 3'(i + 1);
				end
			end
		end else if (mode_ff == MODE_HISTORY) begin
			if (step_ff == 4'h0) begin
				nxt_disp.kind = DISP_TITLE;
			end else begin
				nxt_disp.slot = 3'(slot_idx + 4'h1);
				if (!hist_valid_ff[slot_idx[2:0]]) begin
					nxt_disp.kind = DISP_BLANK;
				end else if (step_ff[0]) begin
					nxt_disp.kind  = DISP_POINTS;
					nxt_disp.value = hist_ff[slot_idx[2:0]].points;
				end else begin
					nxt_disp.kind  = DISP_TICKETS;
					nxt_disp.value = hist_ff[slot_idx[2:0]].tickets;
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			DISPLAY <= '{kind: DISP_IDLE, slot: 3'h0, value: '0};
		end else begin
			DISPLAY <= nxt_disp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Audit tallies
	logic [TALLY_W-1:0] games_ff;
	logic [TALLY_W-1:0] ball_ff [NUM_BALL];
	logic [TALLY_W-1:0] gate_tally_ff;
	logic [TALLY_W-1:0] sensor_tally_ff;
	logic               audit_clear;
	logic               frozen;

	assign frozen = (games_ff == GAMES_CEILING);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			games_ff        <= '0;
			gate_tally_ff   <= '0;
			sensor_tally_ff <= '0;
			for (int i = 0; i < NUM_BALL; i++) begin
				ball_ff[i] <= '0;
			end
		end else if (audit_clear) begin
			games_ff        <= '0;
			gate_tally_ff   <= '0;
			sensor_tally_ff <= '0;
			for (int i = 0; i < NUM_BALL; i++) begin
				ball_ff[i] <= '0;
			end
		end else if (!frozen) begin
			games_ff        <= games_ff + TALLY_W'(GAME_END);
			gate_tally_ff   <= gate_tally_ff + TALLY_W'(fault_new[FLT_GATE]);
			sensor_tally_ff <= sensor_tally_ff + TALLY_W'(fault_new[FLT_SENSOR]);
			for (int t = 0; t < NUM_TARGETS; t++) begin
				// Even index counts flashing exits, odd index the rest
				ball_ff[2*t]   <= ball_ff[2*t] + TALLY_W'(beam_rise[t] & TARGET_FLASH[t]);
				ball_ff[2*t+1] <= ball_ff[2*t+1] + TALLY_W'(beam_rise[t] & ~TARGET_FLASH[t]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave and interrupt
	logic        aw_full_ff;
	logic        w_full_ff;
	logic [7:0]  aw_addr_ff;
	logic [31:0] w_data_ff;
	logic        w_lane0_ff;
	logic [4:0]  irq_status_ff;
	logic [4:0]  irq_mask_ff;
	logic        commit;
	logic        rd_take;
	logic        rd_clear;
	logic [31:0] rd_data;

	function automatic logic ghem_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= ADDR_OWED);
	endfunction : ghem_mapped

	assign S_AXI_AWREADY = ~aw_full_ff;
	assign S_AXI_WREADY  = ~w_full_ff;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;
	assign commit        = aw_full_ff & w_full_ff & ~S_AXI_BVALID;
	assign rd_take       = S_AXI_ARVALID & S_AXI_ARREADY;
	assign rd_clear      = rd_take && (S_AXI_ARADDR == ADDR_IRQ_STATUS);
	assign audit_clear   = commit && aw_addr_ff == ADDR_CONTROL && w_lane0_ff && w_data_ff[CTRL_CLEAR_BIT];
	assign IRQ           = |(irq_status_ff & irq_mask_ff);

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_ff   <= 1'b0;
			w_full_ff    <= 1'b0;
			aw_addr_ff   <= '0;
			w_data_ff    <= '0;
			w_lane0_ff   <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= RESP_OKAY;
			irq_mask_ff  <= MASK_RESET;
		end else begin
			if (S_AXI_AWVALID && !aw_full_ff) begin
				aw_full_ff <= 1'b1;
				aw_addr_ff <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && !w_full_ff) begin
				w_full_ff  <= 1'b1;
				w_data_ff  <= S_AXI_WDATA;
				w_lane0_ff <= S_AXI_WSTRB[0];
			end
			if (commit) begin
				aw_full_ff   <= 1'b0;
				w_full_ff    <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= ghem_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
				if (aw_addr_ff == ADDR_IRQ_MASK && w_lane0_ff) begin
					irq_mask_ff <= w_data_ff[4:0];
				end
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	// Read clears status; an event in the same cycle still lands
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_ff <= '0;
		end else begin
			irq_status_ff <= (irq_status_ff & ~{5{rd_clear}}) | fault_new;
		end
	end

	always_comb begin
		rd_data = '0;
		case (S_AXI_ARADDR)
			ADDR_GAMES:        rd_data = 32'(games_ff);
			ADDR_GATE_TALLY:   rd_data = 32'(gate_tally_ff);
			ADDR_SENSOR_TALLY: rd_data = 32'(sensor_tally_ff);
			ADDR_IRQ_STATUS:   rd_data = 32'(irq_status_ff);
			ADDR_IRQ_MASK:     rd_data = 32'(irq_mask_ff);
			ADDR_FAULTS:       rd_data = 32'(faults_ff);
			ADDR_OWED:         rd_data = 32'(owed_ff);
			default: begin
				for (int i = 0; i < NUM_BALL; i++) begin
					if (S_AXI_ARADDR == ADDR_BALL_BASE + 8'(4 * i)) begin
						rd_data = 32'(ball_ff[i]);
					end
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= '0;
			S_AXI_RRESP  <= RESP_OKAY;
		end else if (rd_take) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_data;
			S_AXI_RRESP  <= ghem_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end
endmodule : ghem_top
`default_nettype wire

// [verilog/ghem_pkg.sv]
// Constants and types for the game history and error monitor
`default_nettype none
package ghem_pkg;
	// Clock and supervision times
	localparam int CLK_HZ            = 10_000_000;
	localparam int NOTCH_TIMEOUT_MS  = 3000;
	localparam int NOTCH_TIMEOUT_CYC = NOTCH_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int COIN_STUCK_MS     = 5000;
	localparam int COIN_STUCK_CYC    = COIN_STUCK_MS * (CLK_HZ / 1000);
	localparam int BEAM_BLOCK_MS     = 3000;
	localparam int BEAM_BLOCK_CYC    = BEAM_BLOCK_MS * (CLK_HZ / 1000);
	localparam int TMR_W             = 26;
	// Sizes
	localparam int NUM_TARGETS = 3;
	localparam int NUM_HIST    = 5;
	localparam int NUM_BALL    = 2 * NUM_TARGETS;
	localparam int NUM_FAULTS  = 5;
	localparam int VAL_W       = 10;
	localparam int TALLY_W     = 16;
	localparam int OWED_W      = 12;
	// Counts and limits
	localparam logic [TALLY_W-1:0] GAMES_CEILING       = 16'hEA60;
	localparam logic [3:0]         HIST_LAST_STEP      = 4'hA;
	localparam logic [2:0]         AUDIT_ENTRY_PRESSES = 3'h5;
	// Fault indices
	localparam int FLT_TICKET = 0;
	localparam int FLT_COIN   = 1;
	localparam int FLT_MEM    = 2;
	localparam int FLT_GATE   = 3;
	localparam int FLT_SENSOR = 4;
	// Register byte offsets
	localparam logic [7:0] ADDR_GAMES        = 8'h00;
	localparam logic [7:0] ADDR_BALL_BASE    = 8'h04;
	localparam logic [7:0] ADDR_GATE_TALLY   = 8'h1C;
	localparam logic [7:0] ADDR_SENSOR_TALLY = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h24;
	localparam logic [7:0] ADDR_IRQ_MASK     = 8'h28;
	localparam logic [7:0] ADDR_CONTROL      = 8'h2C;
	localparam logic [7:0] ADDR_FAULTS       = 8'h30;
	localparam logic [7:0] ADDR_OWED         = 8'h34;
	localparam int         CTRL_CLEAR_BIT    = 0;
	localparam logic [4:0] MASK_RESET        = 5'h00;
	localparam logic [1:0] RESP_OKAY         = 2'h0;
	localparam logic [1:0] RESP_SLVERR       = 2'h2;
	// Types
	typedef enum {MODE_ATTRACT, MODE_TEST, MODE_AUDIT, MODE_HISTORY} ghem_mode_type;
	typedef enum logic [2:0] {DISP_IDLE, DISP_TITLE, DISP_POINTS, DISP_TICKETS, DISP_BLANK,
		DISP_ERROR} ghem_disp_kind_type;
	typedef struct packed {
		logic [VAL_W-1:0] points;
		logic [VAL_W-1:0] tickets;
	} ghem_hist_type;
	typedef struct packed {
		ghem_disp_kind_type kind;
		logic [2:0]         slot;
		logic [VAL_W-1:0]   value;
	} ghem_disp_type;
endpackage : ghem_pkg
`default_nettype wire

// [tb/ghem_top_asserts.sv]
// Port checker for the history and fault monitor
`default_nettype none
module ghem_top_asserts #(
	parameter int NUM_COIN    = 2,
	parameter int NOTCH_LIMIT = 20,
	parameter int COIN_LIMIT  = 30,
	parameter int BEAM_LIMIT  = 20
) (
	// Clock and reset
	input wire logic                  CLK,
	input wire logic                  RESETN,
	// Bus handshakes
	input wire logic                  S_AXI_ARVALID,
	input wire logic                  S_AXI_ARREADY,
	input wire logic                  S_AXI_RVALID,
	input wire logic                  S_AXI_RREADY,
	input wire logic                  S_AXI_BVALID,
	input wire logic                  S_AXI_BREADY,
	// Machine pins
	input wire logic [NUM_COIN-1:0]   COIN_SW,
	input wire logic                  NOTCH,
	input wire logic                  GATE_CLOSED,
	input wire logic [2:0]            TARGET_BEAM,
	input wire logic                  GAME_END,
	// Machine outputs
	input wire ghem_pkg::ghem_disp_type DISPLAY,
	input wire logic                  DISPENSE,
	input wire logic                  GATE_CLOSE_CMD,
	input wire logic                  PLAY_HALT
);
	timeunit 1ns;
	timeprecision 1ns;
	import ghem_pkg::*;
	int stall_ff;
	int coin_ff;
	int beam_ff;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);
	////////////////////////////////////////////////////////////////////////
	// Slack of 8 covers pin sync and output registers
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			stall_ff <= 0;
			coin_ff <= 0;
			beam_ff <= 0;
		end else begin
			stall_ff <= (DISPENSE && !NOTCH) ? stall_ff + 1 : 0;
			coin_ff <= (|COIN_SW) ? coin_ff + 1 : 0;
			beam_ff <= (|TARGET_BEAM) ? beam_ff + 1 : 0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read not answered next cycle");
	a_write_done: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
		else $error("write response repeated");
	a_ticket_stall: assert property (stall_ff <= NOTCH_LIMIT + 8)
		else $error("dispensing goes on without notch");
	a_coin_stuck: assert property (coin_ff >= COIN_LIMIT + 8 |-> PLAY_HALT)
		else $error("stuck coin switch not halting");
	a_beam_block: assert property (beam_ff >= BEAM_LIMIT + 8 |-> PLAY_HALT)
		else $error("blocked beam not halting");
	a_gate_open: assert property ((!GATE_CLOSED) [*4] ##0 GAME_END |-> ##[1:6] PLAY_HALT)
		else $error("open gate at game end not flagged");
	a_gate_cmd_pulse: assert property (GATE_CLOSE_CMD |=> !GATE_CLOSE_CMD)
		else $error("gate close command longer than a pulse");
	a_halt_shows: assert property ($rose(PLAY_HALT) |-> ##[0:2] DISPLAY.kind == DISP_ERROR)
		else $error("halt without error display");
	c_game_end: cover property (GAME_END);
	c_gate_cmd: cover property (GATE_CLOSE_CMD);
	c_title: cover property (DISPLAY.kind == DISP_TITLE);
endmodule : ghem_top_asserts
bind ghem_top ghem_top_asserts #(.NUM_COIN(NUM_COIN), .NOTCH_LIMIT(NOTCH_LIMIT), .COIN_LIMIT(COIN_LIMIT),
	.BEAM_LIMIT(BEAM_LIMIT)) chk (.*);
`default_nettype wire

// [tb/ghem_feeder.sv]
// Ticket dispenser model driving the notch sensor
`default_nettype none
module ghem_feeder (
	// Clock and reset
	input wire logic   clk,
	input wire logic   rst_n,
	// Dispenser drive
	input wire logic   dispense,
	input wire logic   jam,
	// Notch and paid tally
	output logic       notch,
	output logic [15:0] paid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] phase_ff;
	// A jammed feeder never moves the notch
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= 3'h0;
			notch <= 1'b0;
			paid <= 16'h0000;
		end else if (dispense && !jam) begin
			phase_ff <= phase_ff + 3'h1;
			notch <= phase_ff[2] & phase_ff[1];
			if (phase_ff == 3'h6) paid <= paid + 16'h0001;
		end else begin
			phase_ff <= 3'h0;
			notch <= 1'b0;
		end
	end
endmodule : ghem_feeder
`default_nettype wire

// [tb/test_ghem_top.sv]
// Self-checking bench for the history and fault monitor
`default_nettype none
module test_ghem_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ghem_pkg::*;
	logic          CLK = 0, RESETN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
	logic          S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, IRQ;
	logic          TEST_BTN, SERVICE_BTN, NOTCH, GATE_CLOSED, GAME_END, SETTINGS_MEM_ERR;
	logic          VOICE_REQ, DISPENSE, GATE_CLOSE_CMD, PLAY_HALT, jam;
	logic [7:0]    S_AXI_AWADDR, S_AXI_ARADDR;
	logic [31:0]   S_AXI_WDATA, S_AXI_RDATA;
	logic [3:0]    S_AXI_WSTRB;
	logic [1:0]    S_AXI_BRESP, S_AXI_RRESP, COIN_SW;
	logic [2:0]    TARGET_BEAM, TARGET_FLASH;
	logic [9:0]    GAME_POINTS, GAME_TICKETS;
	logic [15:0]   paid;
	logic [9:0]    hp[$], ht[$];
	ghem_disp_type DISPLAY;
	int            err_count = 0, n_compared = 0, voices = 0, gcmds = 0;
	ghem_top #(.NOTCH_LIMIT(20), .COIN_LIMIT(30), .BEAM_LIMIT(20)) uut (.*);
	ghem_feeder fd (.clk(CLK), .rst_n(RESETN), .dispense(DISPENSE), .jam(jam), .notch(NOTCH), .paid(paid));
	initial forever #50 CLK = ~CLK;
	always @(posedge CLK) begin
		voices <= voices + int'(VOICE_REQ === 1'b1);
		gcmds <= gcmds + int'(GATE_CLOSE_CMD === 1'b1);
	end
	initial begin
		#2_000_000;
		err_count++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
		@(posedge CLK);
		S_AXI_ARADDR <= a;
		S_AXI_ARVALID <= 1;
		S_AXI_RREADY <= 1;
		for (int n = 0; n < 50; n++) begin
			@(posedge CLK);
			if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
			if (S_AXI_RVALID) break;
		end
		if (!S_AXI_RVALID) err_count++;
		chk(S_AXI_RDATA, e);
		chk(S_AXI_RRESP, r);
		S_AXI_RREADY <= 0;
	endtask : rd
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
		@(posedge CLK);
		S_AXI_AWADDR <= a;
		S_AXI_WDATA <= d;
		S_AXI_AWVALID <= 1;
		S_AXI_WVALID <= 1;
		S_AXI_BREADY <= 1;
		for (int n = 0; n < 50; n++) begin
			@(posedge CLK);
			if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
			if (S_AXI_WREADY) S_AXI_WVALID <= 0;
			if (S_AXI_BVALID) break;
		end
		if (!S_AXI_BVALID) err_count++;
		chk(S_AXI_BRESP, r);
		S_AXI_BREADY <= 0;
	endtask : wr
	task press(input bit s);
		@(posedge CLK);
		if (s) SERVICE_BTN <= 1;
		else TEST_BTN <= 1;
		repeat (4) @(posedge CLK);
		TEST_BTN <= 0;
		SERVICE_BTN <= 0;
		repeat (8) @(posedge CLK);
	endtask : press
	task drain();
		for (int n = 0; n < 400 && (n < 4 || DISPENSE); n++) @(posedge CLK);
	endtask : drain
	task game(input logic [9:0] p, t);
		@(posedge CLK);
		GAME_END <= 1;
		GAME_POINTS <= p;
		GAME_TICKETS <= t;
		@(posedge CLK);
		GAME_END <= 0;
		hp.push_front(p);
		ht.push_front(t);
		drain();
	endtask : game
	task browse();
		int g;
		ghem_disp_type exp_disp;
		repeat (6) press(0);
		chk(DISPLAY.kind, DISP_TITLE);
		for (int s = 1; s <= 11; s++) begin
			press(1);
			g = (s - 1) % 10 / 2;
			exp_disp = {(s % 2) ? DISP_POINTS : DISP_TICKETS, 3'(g + 1), (s % 2) ? hp[g] : ht[g]};
			if (g < hp.size()) chk(DISPLAY, exp_disp);
			else chk(DISPLAY.kind, DISP_BLANK);
		end
		press(0);
		chk(DISPLAY.kind, DISP_IDLE);
	endtask : browse
	////////////////////////////////////////////////////////////////////////
	task t_ball();
		for (int t = 0; t < 3; t++) for (int k = 0; k <= t + 1; k++) begin
			@(posedge CLK);
			TARGET_FLASH[t] <= (k != 0);
			TARGET_BEAM[t] <= 1;
			repeat (3) @(posedge CLK);
			TARGET_BEAM[t] <= 0;
			repeat (6) @(posedge CLK);
		end
		for (int t = 0; t < 3; t++) begin
			rd(ADDR_BALL_BASE + 8'(8 * t), t + 1);
			rd(ADDR_BALL_BASE + 8'(8 * t + 4), 1);
		end
		$display("ball tally test done");
	endtask : t_ball
	task t_hist();
		for (int i = 1; i <= 3; i++) game(10'(i * 37), 10'(i));
		browse();
		for (int i = 4; i <= 6; i++) game(10'(i * 101), 10'(i));
		browse();
		rd(ADDR_GAMES, 6);
		rd(ADDR_OWED, 0);
		$display("history test done");
	endtask : t_hist
	task t_ticket();
		int v;
		v = voices;
		jam <= 1;
		game(10'h064, 10'h005);
		rd(ADDR_OWED, 5);
		chk({DISPLAY.kind, DISPLAY.slot}, {DISP_ERROR, 3'h1});
		chk(voices, v + 1);
		chk(IRQ, 0);
		wr(ADDR_IRQ_MASK, 1);
		chk(IRQ, 1);
		rd(ADDR_IRQ_STATUS, 1);
		chk(IRQ, 0);
		jam <= 0;
		v = paid;
		press(0);
		drain();
		chk(paid - v, 5);
		chk(PLAY_HALT, 0);
		$display("ticket test done");
	endtask : t_ticket
	task t_coin();
		COIN_SW <= 2'b01;
		repeat (25) @(posedge CLK);
		chk(PLAY_HALT, 0);
		repeat (15) @(posedge CLK);
		chk({DISPLAY.kind, DISPLAY.slot}, {DISP_ERROR, 3'h2});
		press(0);
		chk(PLAY_HALT, 1);
		COIN_SW <= 0;
		press(0);
		chk(PLAY_HALT, 0);
		$display("coin test done");
	endtask : t_coin
	task t_gate();
		int g;
		g = gcmds;
		GATE_CLOSED <= 0;
		repeat (4) @(posedge CLK);
		game(10'h000, 10'h000);
		chk({DISPLAY.kind, DISPLAY.slot}, {DISP_ERROR, 3'h4});
		press(0);
		chk(gcmds - g, 1);
		chk(PLAY_HALT, 0);
		GATE_CLOSED <= 1;
		rd(ADDR_GATE_TALLY, 1);
		$display("gate test done");
	endtask : t_gate
	task t_sensor();
		TARGET_BEAM[1] <= 1;
		repeat (15) @(posedge CLK);
		chk(PLAY_HALT, 0);
		repeat (15) @(posedge CLK);
		chk({DISPLAY.kind, DISPLAY.slot}, {DISP_ERROR, 3'h5});
		TARGET_BEAM[1] <= 0;
		repeat (8) @(posedge CLK);
		chk(PLAY_HALT, 0);
		rd(ADDR_SENSOR_TALLY, 1);
		$display("sensor test done");
	endtask : t_sensor
	task t_clear();
		wr(ADDR_CONTROL, 1);
		rd(ADDR_GAMES, 0);
		rd(ADDR_SENSOR_TALLY, 0);
		rd(ADDR_CONTROL, 0);
		rd(8'h3C, 0, RESP_SLVERR);
		wr(8'h3C, 1, RESP_SLVERR);
		$display("clear test done");
	endtask : t_clear
	task t_mem();
		SETTINGS_MEM_ERR <= 1;
		repeat (8) @(posedge CLK);
		chk(PLAY_HALT, 0);
		press(0);
		chk({DISPLAY.kind, DISPLAY.slot}, {DISP_ERROR, 3'h3});
		$display("memory test done");
	endtask : t_mem
	task stop_test();
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////////////
	initial begin
		{S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, COIN_SW, TARGET_BEAM, TARGET_FLASH} = '0;
		{S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
		{TEST_BTN, SERVICE_BTN, GAME_END, SETTINGS_MEM_ERR, jam, GAME_POINTS, GAME_TICKETS} = '0;
		S_AXI_WSTRB = 4'hF;
		GATE_CLOSED = 1;
		RESETN = 0;
		repeat (5) @(posedge CLK);
		RESETN <= 1;
		repeat (4) @(posedge CLK);
		t_ball();
		t_hist();
		t_ticket();
		t_coin();
		t_gate();
		t_sensor();
		t_clear();
		t_mem();
		stop_test();
	end
endmodule : test_ghem_top
`default_nettype wire
